// ### src/tfad_regs.vh
`ifndef TFAD_REGS_VH
`define TFAD_REGS_VH

// Configuration index values selecting the decode layout
`define TFAD_IDX_MEM 2'h0
`define TFAD_IDX_CONTIG 2'h1
`define TFAD_IDX_PRI 2'h2
`define TFAD_IDX_SEC 2'h3

// Task file offsets
`define TFAD_OFS_DATA 4'h0
`define TFAD_OFS_FAULT 4'h1
`define TFAD_OFS_COUNT 4'h2
`define TFAD_OFS_SECTOR 4'h3
`define TFAD_OFS_TRK_LO 4'h4
`define TFAD_OFS_TRK_HI 4'h5
`define TFAD_OFS_UNIT 4'h6
`define TFAD_OFS_STATE 4'h7
`define TFAD_OFS_EVEN 4'h8
`define TFAD_OFS_ODD 4'h9
`define TFAD_OFS_MFAULT 4'hd
`define TFAD_OFS_SHADOW 4'he
`define TFAD_OFS_UADDR 4'hf

// Upper address field A9..A4 for the I/O layouts
`define TFAD_PRI_BLK 6'h1f
`define TFAD_PRI_ALT 6'h3f
`define TFAD_SEC_BLK 6'h17
`define TFAD_SEC_ALT 6'h37
// A2..A1 of the alternate pair at offsets 6 and 7
`define TFAD_ALT_A21 2'h3

// Configuration table bytes, indexed by entry
`define TFAD_CT_IO1_LSB 8'hf0
`define TFAD_CT_IO1_MSB 8'h01
`define TFAD_CT_IO1_LEN 8'h07
`define TFAD_CT_IO2_LSB 8'hf6
`define TFAD_CT_IO2_MSB 8'h03
`define TFAD_CT_IO2_LEN 8'h01
`define TFAD_CT_IRQ_DESC 8'hee
`define TFAD_CT_IRQ_MASK 8'hff
`define TFAD_CT_MISC 8'h20
`define TFAD_CT_SEL_IO1_LSB 3'h0
`define TFAD_CT_SEL_IO1_MSB 3'h1
`define TFAD_CT_SEL_IO1_LEN 3'h2
`define TFAD_CT_SEL_IO2_LSB 3'h3
`define TFAD_CT_SEL_IO2_MSB 3'h4
`define TFAD_CT_SEL_IO2_LEN 3'h5
`define TFAD_CT_SEL_IRQ 3'h6
`define TFAD_CT_SEL_MISC 3'h7

// Reset values and status/control bit positions
`define TFAD_RST_COUNT 8'h01
`define TFAD_RST_STATE 8'h50
`define TFAD_RST_UNIT 8'ha0
`define TFAD_STS_BSY 7
`define TFAD_CTL_NIEN 1

`endif

// ### src/tfad_decode.v
`timescale 1ns/100ps
`default_nettype none
`include "tfad_regs.vh"

// Pure address decode: yields a hit and a task file offset
module tfad_decode (
    input wire [1:0] cfg_index,
    input wire reg_n,
    input wire [10:0] addr,
    output reg hit,
    output reg [3:0] offset
);
    always @* begin
        hit = 1'b0;
        offset = addr[3:0];
        case (cfg_index)
            `TFAD_IDX_MEM: begin
                if (reg_n) begin
                    hit = 1'b1;
                    if (addr[10])
                        offset = addr[0] ? `TFAD_OFS_ODD : `TFAD_OFS_EVEN;
                end
            end
            `TFAD_IDX_CONTIG: begin
                hit = ~reg_n;
            end
            `TFAD_IDX_PRI: begin
                if (!reg_n && addr[9:4] == `TFAD_PRI_BLK && !addr[3])
                    hit = 1'b1;
                if (!reg_n && addr[9:4] == `TFAD_PRI_ALT && !addr[3]
                        && addr[2:1] == `TFAD_ALT_A21)
                    hit = 1'b1;
                if (addr[9:4] == `TFAD_PRI_ALT)
                    offset = {1'b1, addr[2:0]};
            end
            default: begin
                if (!reg_n && addr[9:4] == `TFAD_SEC_BLK && !addr[3])
                    hit = 1'b1;
                if (!reg_n && addr[9:4] == `TFAD_SEC_ALT && !addr[3]
                        && addr[2:1] == `TFAD_ALT_A21)
                    hit = 1'b1;
                if (addr[9:4] == `TFAD_SEC_ALT)
                    offset = {1'b1, addr[2:0]};
            end
        endcase
        // Offsets A to C are holes in the contiguous layouts
        if (offset > `TFAD_OFS_ODD && offset < `TFAD_OFS_MFAULT)
            hit = 1'b0;
    end
endmodule // tfad_decode

`default_nettype wire

// ### src/tfad_cfg_table.v
`timescale 1ns/100ps
`default_nettype none
`include "tfad_regs.vh"

// Constant configuration table entries advertised to the host
module tfad_cfg_table (
    input wire [2:0] sel,
    output reg [7:0] data
);
    always @* begin
        case (sel)
            `TFAD_CT_SEL_IO1_LSB: data = `TFAD_CT_IO1_LSB;
            `TFAD_CT_SEL_IO1_MSB: data = `TFAD_CT_IO1_MSB;
            `TFAD_CT_SEL_IO1_LEN: data = `TFAD_CT_IO1_LEN;
            `TFAD_CT_SEL_IO2_LSB: data = `TFAD_CT_IO2_LSB;
            `TFAD_CT_SEL_IO2_MSB: data = `TFAD_CT_IO2_MSB;
            `TFAD_CT_SEL_IO2_LEN: data = `TFAD_CT_IO2_LEN;
            `TFAD_CT_SEL_IRQ: data = `TFAD_CT_IRQ_DESC;
            `TFAD_CT_SEL_MISC: data = `TFAD_CT_MISC;
            default: data = `TFAD_CT_MISC;
        endcase
    end
endmodule // tfad_cfg_table

`default_nettype wire

// ### src/tfad_top.v
`timescale 1ns/100ps
`default_nettype none
`include "tfad_regs.vh"

// Overview of operation
// - Configuration index 0..3 picks one decode layout; only it applies.
// - Index 0: memory cycles, reg select high, A10 selects even/odd data port.
// - Index 1: I/O cycles, reg select low, only A3..A0 decoded.
// - Index 2: A9..A4 1F for offsets 0-7, 3F for offsets 6,7 alternates.
// - Index 3: A9..A4 17 for offsets 0-7, 37 for offsets 6,7 alternates.
// - Offsets 0-7: data, error/feature, count, sector, track lo/hi, unit, status/command.
// - Indices 0,1: 8/9 byte data mirrors, D mirrors error/feature, A-C undecoded.
// - Offset E alt status/device control; F drive address read, writes ignored.
// - First I/O range advertised as F0, 01, length-1 07.
// - Second I/O range advertised as F6, 03, length-1 01.
// - Interrupt descriptor EE: shared, pulse and level, fixed level 14.
// - Contiguous entry mask extension bytes both FF.
// - Misc features byte 20: power down, writable, no audio, single drive.
// - Data port is 16 bits, word and byte accesses allowed.
// - Status read drops interrupt request; alternate status read does not.
module tfad_top (
    input wire core_clk,
    input wire arst_n,
    input wire [1:0] cfg_index,
    input wire reg_n,
    input wire [10:0] addr,
    input wire oe_n,
    input wire we_n,
    input wire iord_n,
    input wire iowr_n,
    input wire byte_mode,
    input wire [15:0] data_in,
    output reg [15:0] data_out,
    output reg data_oe,
    input wire [7:0] core_status,
    input wire [7:0] core_fault,
    input wire core_irq_set,
    input wire [15:0] core_rd_word,
    output reg [15:0] core_wr_word,
    output reg core_wr_valid,
    output reg core_rd_take,
    output reg [7:0] opcode,
    output reg opcode_valid,
    output reg [7:0] feature_q,
    output reg [7:0] count_q,
    output reg [7:0] sector_q,
    output reg [7:0] trk_lo_q,
    output reg [7:0] trk_hi_q,
    output reg [7:0] unit_q,
    output reg [7:0] unit_ctl_q,
    output reg irq_req,
    input wire [3:0] ct_sel,
    output reg [7:0] ct_data
);
    reg rst_s1_q;
    reg rst_s2_q;
    wire rst_n;
    reg rd_q;
    reg wr_q;
    wire rd_lvl;
    wire wr_lvl;
    wire rd_edge;
    wire wr_edge;
    wire hit;
    wire [3:0] ofs;
    wire [7:0] tbl_byte;
    reg odd_phase_q;
    reg [7:0] low_byte_q;
    reg [15:0] rd_mux;

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    assign rst_n = rst_s2_q;

    // Strobe family follows the layout: memory strobes only for index 0
    assign rd_lvl = (cfg_index == `TFAD_IDX_MEM) ? ~oe_n : ~iord_n;
    assign wr_lvl = (cfg_index == `TFAD_IDX_MEM) ? ~we_n : ~iowr_n;

    tfad_decode u_dec (
        .cfg_index(cfg_index),
        .reg_n(reg_n),
        .addr(addr),
        .hit(hit),
        .offset(ofs)
    );

    tfad_cfg_table u_tbl (
        .sel(ct_sel[2:0]),
        .data(tbl_byte)
    );

    // Mask extension bytes live above the base eight entries
    always @* begin
        ct_data = ct_sel[3] ? `TFAD_CT_IRQ_MASK : tbl_byte;
    end

    // Edge detect so a long host strobe acts once
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
        end else begin
            rd_q <= rd_lvl & hit;
            wr_q <= wr_lvl & hit;
        end
    end
    assign rd_edge = rd_lvl & hit & ~rd_q;
    assign wr_edge = wr_lvl & hit & ~wr_q;

    always @* begin
        rd_mux = 16'h0000;
        case (ofs)
            `TFAD_OFS_DATA: rd_mux = core_rd_word;
            `TFAD_OFS_FAULT: rd_mux = {8'h00, core_fault};
            `TFAD_OFS_COUNT: rd_mux = {8'h00, count_q};
            `TFAD_OFS_SECTOR: rd_mux = {8'h00, sector_q};
            `TFAD_OFS_TRK_LO: rd_mux = {8'h00, trk_lo_q};
            `TFAD_OFS_TRK_HI: rd_mux = {8'h00, trk_hi_q};
            `TFAD_OFS_UNIT: rd_mux = {8'h00, unit_q};
            `TFAD_OFS_STATE: rd_mux = {8'h00, core_status};
            `TFAD_OFS_EVEN: rd_mux = {8'h00, core_rd_word[7:0]};
            `TFAD_OFS_ODD: rd_mux = {8'h00, core_rd_word[15:8]};
            `TFAD_OFS_MFAULT: rd_mux = {8'h00, core_fault};
            `TFAD_OFS_SHADOW: rd_mux = {8'h00, core_status};
            `TFAD_OFS_UADDR: rd_mux = {8'h00, 2'h0, ~unit_q[3:0], ~unit_q[4], 1'b1};
            default: rd_mux = 16'h0000;
        endcase
    end

    // Read data and bus enable registered; undriven outside a hit
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_out <= 16'h0000;
            data_oe <= 1'b0;
        end else begin
            data_oe <= rd_lvl & hit;
            if (rd_lvl & hit)
                data_out <= rd_mux;
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            feature_q <= 8'h00;
            count_q <= `TFAD_RST_COUNT;
            sector_q <= `TFAD_RST_COUNT;
            trk_lo_q <= 8'h00;
            trk_hi_q <= 8'h00;
            unit_q <= `TFAD_RST_UNIT;
            unit_ctl_q <= 8'h00;
            opcode <= 8'h00;
            opcode_valid <= 1'b0;
            core_wr_word <= 16'h0000;
            core_wr_valid <= 1'b0;
            core_rd_take <= 1'b0;
            odd_phase_q <= 1'b0;
            low_byte_q <= 8'h00;
            irq_req <= 1'b0;
        end else begin
            opcode_valid <= 1'b0;
            core_wr_valid <= 1'b0;
            core_rd_take <= 1'b0;
            // Byte mode pairs low then high byte into one word
            if (wr_edge) begin
                case (ofs)
                    `TFAD_OFS_DATA, `TFAD_OFS_EVEN, `TFAD_OFS_ODD: begin
                        if (!byte_mode && ofs == `TFAD_OFS_DATA) begin
                            core_wr_word <= data_in;
                            core_wr_valid <= 1'b1;
                        end else if (!odd_phase_q) begin
                            low_byte_q <= data_in[7:0];
                            odd_phase_q <= 1'b1;
                        end else begin
                            core_wr_word <= {data_in[7:0], low_byte_q};
                            core_wr_valid <= 1'b1;
                            odd_phase_q <= 1'b0;
                        end
                    end
                    `TFAD_OFS_FAULT, `TFAD_OFS_MFAULT: feature_q <= data_in[7:0];
                    `TFAD_OFS_COUNT: count_q <= data_in[7:0];
                    `TFAD_OFS_SECTOR: sector_q <= data_in[7:0];
                    `TFAD_OFS_TRK_LO: trk_lo_q <= data_in[7:0];
                    `TFAD_OFS_TRK_HI: trk_hi_q <= data_in[7:0];
                    `TFAD_OFS_UNIT: unit_q <= data_in[7:0];
                    `TFAD_OFS_STATE: begin
                        opcode <= data_in[7:0];
                        opcode_valid <= 1'b1;
                    end
                    `TFAD_OFS_SHADOW: unit_ctl_q <= data_in[7:0];
                    default: begin
                        // Drive address writes are reserved and dropped
                    end
                endcase
            end
            // Word reads consume one word; byte reads consume on the odd byte
            if (rd_edge) begin
                if (ofs == `TFAD_OFS_ODD)
                    core_rd_take <= 1'b1;
                else if (ofs == `TFAD_OFS_DATA && (!byte_mode || odd_phase_q))
                    core_rd_take <= 1'b1;
                if (ofs == `TFAD_OFS_DATA && byte_mode)
                    odd_phase_q <= ~odd_phase_q;
            end
            // Raise wins over status read clear in the same cycle
            if (core_irq_set && !unit_ctl_q[`TFAD_CTL_NIEN])
                irq_req <= 1'b1;
            else if (rd_edge && ofs == `TFAD_OFS_STATE)
                irq_req <= 1'b0;
        end
    end
endmodule // tfad_top

`default_nettype wire

// ### tb/tfad_properties.sv
`timescale 1ns/100ps
`default_nettype none
module tfad_properties (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [1:0] cfg_index,
    input wire logic reg_n,
    input wire logic [10:0] addr,
    input wire logic iord_n,
    input wire logic iowr_n,
    input wire logic [15:0] data_in,
    input wire logic [15:0] data_out,
    input wire logic data_oe,
    input wire logic [7:0] core_status,
    input wire logic core_irq_set,
    input wire logic [7:0] opcode,
    input wire logic opcode_valid,
    input wire logic irq_req,
    input wire logic [3:0] ct_sel,
    input wire logic [7:0] ct_data
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // Status place of the primary layout; A10 is a don't-care there
    wire logic st_hit = !reg_n && cfg_index == 2'h2 && addr[9:0] == 10'h1f7;
    wire logic alt_hit = !reg_n && cfg_index == 2'h2 && addr[9:0] == 10'h3f6;
    wire logic [7:0] wr_byte = data_in[7:0];
    io1_base_a: assert property (ct_sel == 4'h0 |-> ct_data == 8'hf0)
        else $error("first range base byte wrong");
    irq_desc_a: assert property (ct_sel == 4'h6 |-> ct_data == 8'hee)
        else $error("interrupt descriptor wrong");
    irq_mask_a: assert property (ct_sel[3] |-> ct_data == 8'hff)
        else $error("mask extension byte wrong");
    space_miss_a: assert property ((reg_n == (cfg_index != 2'h0))[*2]
        |-> !data_oe) else $error("bus driven on the wrong space");
    alt_hole_a: assert property ((cfg_index[1] && addr[3])[*2]
        |-> !data_oe) else $error("bus driven with A3 high");
    status_rd_a: assert property ($fell(iord_n) && st_hit
        |=> data_oe && data_out[7:0] == $past(core_status)) else $error("status read wrong");
    irq_clear_a: assert property ($fell(iord_n) && st_hit && !core_irq_set
        |=> !irq_req) else $error("status read left interrupt up");
    alt_keep_a: assert property ($fell(iord_n) && alt_hit && irq_req
        |=> irq_req) else $error("alternate status read dropped interrupt");
    cmd_pulse_a: assert property ($fell(iowr_n) && st_hit
        |=> opcode_valid && opcode == $past(wr_byte) ##1 !opcode_valid) else $error("command lost");
endmodule // tfad_properties

bind tfad_top tfad_properties u_tfad_properties (.core_clk, .arst_n, .cfg_index, .reg_n, .addr,
    .iord_n, .iowr_n, .data_in, .data_out, .data_oe, .core_status, .core_irq_set, .opcode,
    .opcode_valid, .irq_req, .ct_sel, .ct_data);
`default_nettype wire

// ### tb/tfad_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// Host adapter: space, address and data held for the whole strobe
module tfad_host_model (
    input wire logic core_clk,
    output logic reg_n,
    output logic [10:0] addr,
    output logic oe_n,
    output logic we_n,
    output logic iord_n,
    output logic iowr_n,
    output logic [15:0] data_in
);
    initial begin
        reg_n = 1'b0;
        addr = 11'h0;
        {oe_n, we_n, iord_n, iowr_n} = 4'hf;
        data_in = 16'h0;
    end
    // Released data lines show the inverse, so a stale value never passes
    task automatic cyc(input logic mem, input logic rs, input logic wr, input logic [10:0] a,
        input logic [15:0] d);
        @(posedge core_clk);
        reg_n <= rs;
        addr <= a;
        data_in <= d;
        {oe_n, we_n, iord_n, iowr_n} <= ~{mem & !wr, mem & wr, !mem & !wr, !mem & wr};
        repeat (3) @(posedge core_clk);
        {oe_n, we_n, iord_n, iowr_n} <= 4'hf;
        data_in <= ~d;
        repeat (2) @(posedge core_clk);
    endtask
endmodule // tfad_host_model
`default_nettype wire

// ### tb/tb_task_file_address_decode.sv
`timescale 1ns/100ps
`default_nettype none
module tb_task_file_address_decode;
    logic core_clk, arst_n, reg_n, oe_n, we_n, iord_n, iowr_n, byte_mode, data_oe, oe_q;
    logic core_irq_set, core_wr_valid, core_rd_take, opcode_valid, irq_req;
    logic [1:0] cfg_index;
    logic [3:0] ct_sel;
    logic [10:0] addr;
    logic [15:0] data_in, data_out, core_rd_word, core_wr_word, w;
    logic [7:0] core_status, core_fault, opcode, feature_q, count_q, sector_q, v;
    logic [7:0] trk_lo_q, trk_hi_q, unit_q, unit_ctl_q, ct_data;
    logic [7:0] ct_exp [8] = '{8'hf0, 8'h01, 8'h07, 8'hf6, 8'h03, 8'h01, 8'hee, 8'h20};
    logic [31:0] e;
    logic [31:0] exp_q[$];
    int num_errors = 0;
    int checks = 0;
    int n_wr = 0;
    int n_take = 0;
    tfad_top u_tfad_top (.core_clk, .arst_n, .cfg_index, .reg_n, .addr, .oe_n, .we_n, .iord_n,
        .iowr_n, .byte_mode, .data_in, .data_out, .data_oe, .core_status, .core_fault,
        .core_irq_set, .core_rd_word, .core_wr_word, .core_wr_valid, .core_rd_take, .opcode,
        .opcode_valid, .feature_q, .count_q, .sector_q, .trk_lo_q, .trk_hi_q, .unit_q,
        .unit_ctl_q, .irq_req, .ct_sel, .ct_data);
    tfad_host_model u_tfad_host_model (.core_clk, .reg_n, .addr, .oe_n, .we_n, .iord_n,
        .iowr_n, .data_in);
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Each fresh drive of the bus answers the oldest outstanding read
    always @(posedge core_clk) begin
        oe_q <= data_oe;
        if (core_wr_valid === 1'b1)
            n_wr++;
        if (core_rd_take === 1'b1)
            n_take++;
        if (data_oe === 1'b1 && oe_q !== 1'b1) begin
            if (exp_q.size() > 0) begin
                e = exp_q.pop_front();
                check("read data", data_out & e[31:16], e[15:0]);
            end else begin
                check("unexpected bus drive", 16'h0001, 16'h0000);
            end
        end
    end
    // Don't-care address bits are random, so they must really be ignored
    function automatic logic [10:0] at(input logic [3:0] o);
        logic [10:0] r;
        r = 11'($urandom);
        if (cfg_index == 2'h0) r[10] = 1'b0;
        // A9..A4: bit 5 marks the alternate pair, bit 3 the primary map
        if (cfg_index[1]) r[9:4] = {o[3], 1'b1, !cfg_index[0], 3'h7};
        r[3:0] = (cfg_index[1] && o[3]) ? {3'h3, o[0]} : o;
        return r;
    endfunction
    task automatic wr(input logic [10:0] a, input logic [15:0] d);
        u_tfad_host_model.cyc(cfg_index == 2'h0, cfg_index == 2'h0, 1'b1, a, d);
    endtask
    task automatic rd(input logic [10:0] a, input logic [15:0] m, input logic [15:0] x);
        exp_q.push_back({m, x & m});
        u_tfad_host_model.cyc(cfg_index == 2'h0, cfg_index == 2'h0, 1'b0, a, 16'h0);
    endtask
    initial begin
        repeat (5000) @(posedge core_clk);
        num_errors++;
        print_verdict();
    end
    initial begin
        void'($urandom(58));
        {arst_n, cfg_index, byte_mode, core_irq_set, ct_sel} = '0;
        {core_status, core_fault, core_rd_word} = '0;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        check("count reset", count_q, 8'h01);
        check("unit reset", unit_q, 8'ha0);
        for (int i = 0; i < 16; i++) begin
            @(posedge core_clk);
            ct_sel <= i[3:0];
            @(negedge core_clk);
            v = (i < 8) ? ct_exp[i] : 8'hff;
            check("table", ct_data, v);
        end
        for (int k = 0; k < 4; k++) begin
            @(posedge core_clk);
            cfg_index <= k[1:0];
            core_status <= 8'($urandom);
            core_fault <= 8'($urandom);
            core_rd_word <= 16'($urandom);
            @(posedge core_clk);
            for (int o = 6; o > 1; o--) begin
                v = 8'($urandom);
                wr(at(4'(o)), {8'h0, v});
                rd(at(4'(o)), 16'h00ff, {8'h0, v});
            end
            u_tfad_host_model.cyc(k == 0, k == 1, 1'b1, at(4'h2) ^ {4'h0, k[1], 6'h0}, ~v);
            check("refused write", count_q, v);
            u_tfad_host_model.cyc(k == 0, k == 0, 1'b0,
                k[1] ? at(4'h2) | 11'h8 : at(4'ha), 16'h0);
            rd(at(4'h7), 16'h00ff, {8'h0, core_status});
            rd(at(4'h1), 16'h00ff, {8'h0, core_fault});
            rd(at(4'he), 16'h00ff, {8'h0, core_status});
            rd(at(4'hf), 16'h0001, 16'h0001);
            wr(at(4'h1), {8'h0, ~v});
            check("feature", feature_q, 8'(~v));
            w = 16'($urandom);
            wr(at(4'h0), w);
            check("word write", core_wr_word, w);
            rd(at(4'h0), 16'hffff, core_rd_word);
            if (!k[1]) begin
                wr(at(4'hd), {8'h0, v});
                check("mirror feature", feature_q, v);
                rd(at(4'hd), 16'h00ff, {8'h0, core_fault});
                byte_mode <= 1'b1;
                wr(at(4'h8), {8'h0, w[15:8]});
                wr(at(4'h9), {8'h0, w[7:0]});
                check("byte write", core_wr_word, {w[7:0], w[15:8]});
                rd(at(4'h8), 16'h00ff, {8'h0, core_rd_word[7:0]});
                rd(at(4'h9), 16'h00ff, {8'h0, core_rd_word[15:8]});
                if (k == 0) begin
                    w = {8'h0, core_rd_word[15:8]};
                    rd({1'b1, 9'($urandom), 1'b1}, 16'h00ff, w);
                end
                byte_mode <= 1'b0;
            end
            wr(at(4'he), 16'h0002);
            check("device control", unit_ctl_q, 8'h02);
            @(posedge core_clk);
            core_irq_set <= 1'b1;
            @(posedge core_clk);
            core_irq_set <= 1'b0;
            wr(at(4'hf), 16'h00fd);
            check("masked irq", irq_req, 1'b0);
            check("reserved write", unit_ctl_q, 8'h02);
            wr(at(4'he), 16'h0000);
            @(posedge core_clk);
            core_irq_set <= 1'b1;
            @(posedge core_clk);
            core_irq_set <= 1'b0;
            rd(at(4'he), 16'h00ff, {8'h0, core_status});
            check("irq after alt read", irq_req, 1'b1);
            rd(at(4'h7), 16'h00ff, {8'h0, core_status});
            check("irq after status read", irq_req, 1'b0);
            wr(at(4'h7), 16'h0020);
            check("command", opcode, 8'h20);
        end
        // Second reset in mid-run: count register must return to its reset value
        @(posedge core_clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        check("count in reset", count_q, 8'h01);
        arst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd(at(4'h2), 16'h00ff, 16'h0001);
        check("pending reads", 16'(exp_q.size()), 16'h0);
        check("word pulses", 16'(n_wr), 16'h0006);
        check("read takes", 16'(n_take), 16'h0007);
        print_verdict();
    end
endmodule // tb_task_file_address_decode
`default_nettype wire
